// File: rtl/data_space_address_decode.sv
// Functional notes
// - Program word: even lower, odd upper
// - Program counter steps by two
// - Reset starts at zero, target at two
// - Vector region below 0x200 reserved
// - Two interrupt vector tables
// - Sixteen-bit byte effective addresses
// - Address bit 15 selects window
// - Unimplemented reads return zero
// - Low byte even, high byte odd
// - Post-increment by one or two
// - Byte read lands on low lane
// - Byte write updates selected lane
// - Odd word access raises trap
// - Misaligned write suppressed, read completes
// - Byte load keeps register high byte
// - Unused special region reads zero
// - Near region via 13-bit field
// - Move reaches full data space
// - Zero and sign extend
`timescale 1ns/10ps
module data_space_address_decode #(
   parameter int IMPL_BYTES = 2048
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_ce,
   // Data access request
   input  wire logic                  i_req,
   input  wire logic                  i_write,
   input  wire logic                  i_byte,
   input  wire logic                  i_near_mode,
   input  wire logic [12:0]           i_near_field,
   input  wire logic [15:0]           i_effective_addr,
   input  wire logic [15:0]           i_wdata,
   input  wire logic                  i_post_inc,
   // Special function region responder
   input  wire logic                  i_sfr_hit,
   input  wire logic [15:0]           i_sfr_rdata,
   // Working register update path
   input  wire logic [15:0]           i_wreg_old,
   input  wire logic [1:0]            i_ext_op,
   // Program window read data
   input  wire logic [15:0]           i_window_rdata,
   // Program counter control
   input  wire logic                  i_pc_step,
   input  wire logic                  i_pc_down,
   input  wire logic                  i_pc_load,
   input  wire logic [23:0]           i_pc_load_addr,
   input  wire logic                  i_err_clear,
   output logic                       o_rvalid,
   output logic [15:0]                o_rdata,
   output logic [15:0]                o_wreg_new,
   output logic [15:0]                o_next_pointer,
   output logic                       o_sfr_wr,
   output logic [1:0]                 o_sfr_we_lane,
   output logic [15:0]                o_sfr_addr,
   output logic [15:0]                o_sfr_wdata,
   output logic                       o_window_sel,
   output logic [14:0]                o_window_addr,
   output logic                       o_addr_err_trap,
   output logic                       o_addr_err_flag,
   output logic [23:0]                o_program_counter,
   output logic                       o_in_vectors,
   output logic                       o_in_ivt1,
   output logic                       o_in_ivt2
);

   localparam int WORDS = IMPL_BYTES / 2;
   localparam int WA_W  = $clog2(WORDS);

   // Elaboration check on the implemented size
   if (IMPL_BYTES < 4 || IMPL_BYTES > int'(dsad_pkg::IMPL_BYTES_MAX) ||
       (IMPL_BYTES & (IMPL_BYTES - 1)) != 0) begin : g_bad_size
      $error("IMPL_BYTES must be a power of two between 4 and 30K");
   end

   typedef struct packed {
      dsad_pkg::phase_t  ph;
      logic              byte_op;
      logic              hi_sel;
      logic              impl;
      logic              sfr;
      logic              win;
      logic [1:0]        ext;
      logic [15:0]       wreg_old;
      logic              rvalid;
      logic [15:0]       rdata;
      logic [15:0]       wreg_new;
      logic [15:0]       next_ptr;
      logic              sfr_wr;
      logic [1:0]        sfr_lane;
      logic [15:0]       sfr_addr;
      logic [15:0]       sfr_wdata;
      logic              win_sel;
      logic [14:0]       win_addr;
      logic              trap;
      logic              flag;
   } dec_state_t;

   dec_state_t st_r;
   dec_state_t st_nxt;

   logic [15:0]   ea;
   logic          misalign;
   logic          is_sfr;
   logic          is_impl;
   logic [1:0]    lane;
   logic [1:0]    ram_we;
   logic [15:0]   ram_rdata;
   logic [15:0]   sel_word;
   logic [7:0]    sel_byte;
   logic [15:0]   rd_val;

   // ==========================================
   // Helpers
   function automatic logic [1:0] lane_of(input logic byte_op, input logic a0);
      lane_of = byte_op ? (a0 ? 2'h2 : 2'h1) : 2'h3;
   endfunction

   function automatic logic [15:0] apply_ext(input logic [15:0] v, input logic [1:0] op);
      case (op)
         dsad_pkg::EXT_ZERO: apply_ext = {8'h00, v[7:0]};
         dsad_pkg::EXT_SIGN: apply_ext = {{8{v[7]}}, v[7:0]};
         default:            apply_ext = v;
      endcase
   endfunction

   // ==========================================
   // Address decode
   always_comb begin
      ea       = i_near_mode ? {3'h0, i_near_field} : i_effective_addr;
      misalign = ~i_byte & ea[0];
      is_sfr   = ~ea[dsad_pkg::WIN_BIT] && ea <= dsad_pkg::SFR_LAST;
      is_impl  = ~ea[dsad_pkg::WIN_BIT] && ~is_sfr && (32'(ea) < IMPL_BYTES);
      lane     = lane_of(i_byte, ea[0]);
      ram_we   = (i_ce && i_req && i_write && ~misalign && is_impl) ? lane : 2'h0;
   end

   data_ram #(
      .WORDS (WORDS)
   ) u_ram (
      .i_clk     (i_clk),
      .i_ce      (i_ce),
      .i_addr    (ea[WA_W:1]),
      .i_we_lane (ram_we),
      .i_wdata   (i_byte ? {i_wdata[7:0], i_wdata[7:0]} : i_wdata),
      .o_rdata   (ram_rdata)
   );

   prog_counter u_pc (
      .i_clk             (i_clk),
      .i_sys_rst         (i_sys_rst),
      .i_ce              (i_ce),
      .i_step            (i_pc_step),
      .i_down            (i_pc_down),
      .i_load            (i_pc_load),
      .i_load_addr       (i_pc_load_addr),
      .o_program_counter (o_program_counter),
      .o_in_vectors      (o_in_vectors),
      .o_in_ivt1         (o_in_ivt1),
      .o_in_ivt2         (o_in_ivt2)
   );

   // ==========================================
   // Next state
   always_comb begin
      st_nxt          = st_r;
      st_nxt.trap     = 1'b0;
      st_nxt.rvalid   = 1'b0;
      st_nxt.sfr_wr   = 1'b0;
      st_nxt.sfr_lane = 2'h0;
      st_nxt.win_sel  = 1'b0;
      st_nxt.ph       = dsad_pkg::PH_IDLE;

      // Completion of a read issued last cycle
      // zero outside implemented data, special region and window
      sel_word = st_r.impl ? ram_rdata :
                 st_r.sfr  ? i_sfr_rdata :
                 st_r.win  ? i_window_rdata : 16'h0000;
      sel_byte = st_r.hi_sel ? sel_word[15:8] : sel_word[7:0];
      rd_val   = st_r.byte_op ? {8'h00, sel_byte} : sel_word;
      if (st_r.ph == dsad_pkg::PH_READ) begin
         st_nxt.rvalid   = 1'b1;
         st_nxt.rdata    = rd_val;
         st_nxt.wreg_new = apply_ext(st_r.byte_op ? {st_r.wreg_old[15:8], sel_byte} : sel_word, st_r.ext);
      end else begin
         st_nxt.wreg_new = apply_ext(i_wreg_old, i_ext_op);
      end

      if (i_req) begin
         st_nxt.byte_op  = i_byte;
         st_nxt.hi_sel   = ea[0];
         st_nxt.impl     = is_impl;
         st_nxt.sfr      = is_sfr;
         st_nxt.win      = ea[dsad_pkg::WIN_BIT];
         st_nxt.ext      = i_ext_op;
         st_nxt.wreg_old = i_wreg_old;
         st_nxt.next_ptr = ea + (i_post_inc ? (i_byte ? dsad_pkg::STEP_BYTE : dsad_pkg::STEP_WORD) : 16'h0000);
         st_nxt.sfr_addr = {ea[15:1], 1'b0};
         st_nxt.win_addr = ea[14:0];
         st_nxt.win_sel  = ea[dsad_pkg::WIN_BIT] & ~i_write;
         st_nxt.ph       = i_write ? dsad_pkg::PH_WRITE : dsad_pkg::PH_READ;
         if (i_write && is_sfr && ~misalign) begin
            st_nxt.sfr_wr    = 1'b1;
            st_nxt.sfr_lane  = lane;
            st_nxt.sfr_wdata = i_byte ? {i_wdata[7:0], i_wdata[7:0]} : i_wdata;
         end
         st_nxt.trap = misalign;
      end
      if (i_err_clear) begin
         st_nxt.flag = 1'b0;
      end
      if (st_nxt.trap) begin
         st_nxt.flag = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_r <= '0;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   // ==========================================
   // Outputs
   assign o_rvalid        = st_r.rvalid;
   assign o_rdata         = st_r.rdata;
   assign o_wreg_new      = st_r.wreg_new;
   assign o_next_pointer  = st_r.next_ptr;
   assign o_sfr_wr        = st_r.sfr_wr;
   assign o_sfr_we_lane   = st_r.sfr_lane;
   assign o_sfr_addr      = st_r.sfr_addr;
   assign o_sfr_wdata     = st_r.sfr_wdata;
   assign o_window_sel    = st_r.win_sel;
   assign o_window_addr   = st_r.win_addr;
   assign o_addr_err_trap = st_r.trap;
   assign o_addr_err_flag = st_r.flag;

endmodule

// File: rtl/dsad_pkg.sv
package dsad_pkg;

   // ==========================================
   // Data space layout
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 16;
   localparam logic [15:0] SFR_LAST        = 16'h07FF;
   localparam logic [15:0] NEAR_LAST       = 16'h1FFF;
   localparam int          NEAR_FIELD_W    = 13;
   localparam logic [15:0] IMPL_BYTES_MAX  = 16'h7800;
   localparam int          WIN_BIT         = 15;
   localparam logic [15:0] STEP_BYTE       = 16'h0001;
   localparam logic [15:0] STEP_WORD       = 16'h0002;

   // ==========================================
   // Program space layout
   localparam int          PADDR_W         = 24;
   localparam logic [23:0] RESET_VEC_ADDR  = 24'h000000;
   localparam logic [23:0] RESET_TGT_ADDR  = 24'h000002;
   localparam logic [23:0] IVT1_FIRST      = 24'h000004;
   localparam logic [23:0] IVT1_LAST       = 24'h0000FF;
   localparam logic [23:0] IVT2_FIRST      = 24'h000100;
   localparam logic [23:0] IVT2_LAST       = 24'h0001FF;
   localparam logic [23:0] VEC_REGION_END  = 24'h000200;
   localparam logic [23:0] PC_STEP         = 24'h000002;
   localparam logic [23:0] PC_RESET        = 24'h000000;

   // ==========================================
   // Extend operations on a working register
   typedef enum logic [1:0] {
      EXT_NONE = 2'b00,
      EXT_ZERO = 2'b01,
      EXT_SIGN = 2'b10
   } ext_op_t;

   // ==========================================
   // Access phase
   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_READ  = 2'b01,
      PH_WRITE = 2'b10
   } phase_t;

endpackage

// File: rtl/data_ram.sv
`timescale 1ns/10ps
module data_ram #(
   parameter int WORDS = 16384
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_ce,
   input  wire logic [$clog2(WORDS)-1:0]     i_addr,
   input  wire logic [1:0]                   i_we_lane,
   input  wire logic [15:0]                  i_wdata,
   output logic      [15:0]                  o_rdata
);

   logic [7:0] lo_mem [WORDS];
   logic [7:0] hi_mem [WORDS];

   // ==========================================
   // Byte lanes with shared decode
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         if (i_we_lane[0]) begin
            lo_mem[i_addr] <= i_wdata[7:0];
         end
         if (i_we_lane[1]) begin
            hi_mem[i_addr] <= i_wdata[15:8];
         end
         o_rdata <= {hi_mem[i_addr], lo_mem[i_addr]};
      end
   end

endmodule

// File: rtl/prog_counter.sv
`timescale 1ns/10ps
module prog_counter (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_ce,
   input  wire logic         i_step,
   input  wire logic         i_down,
   input  wire logic         i_load,
   input  wire logic [23:0]  i_load_addr,
   output logic      [23:0]  o_program_counter,
   output logic              o_in_vectors,
   output logic              o_in_ivt1,
   output logic              o_in_ivt2
);

   typedef struct packed {
      logic [23:0] pc;
      logic        vec;
      logic        iv1;
      logic        iv2;
   } pc_state_t;

   pc_state_t st_r;
   pc_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (i_load) begin
         st_nxt.pc = {i_load_addr[23:1], 1'b0};
      end else if (i_step) begin
         st_nxt.pc = i_down ? st_r.pc - dsad_pkg::PC_STEP : st_r.pc + dsad_pkg::PC_STEP;
      end
      st_nxt.vec = st_nxt.pc < dsad_pkg::VEC_REGION_END;
      st_nxt.iv1 = st_nxt.pc >= dsad_pkg::IVT1_FIRST && st_nxt.pc <= dsad_pkg::IVT1_LAST;
      st_nxt.iv2 = st_nxt.pc >= dsad_pkg::IVT2_FIRST && st_nxt.pc <= dsad_pkg::IVT2_LAST;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_r <= '{pc: dsad_pkg::PC_RESET, vec: 1'b1, iv1: 1'b0, iv2: 1'b0};
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   assign o_program_counter = st_r.pc;
   assign o_in_vectors      = st_r.vec;
   assign o_in_ivt1         = st_r.iv1;
   assign o_in_ivt2         = st_r.iv2;

endmodule

// File: test/sfr_window_model.sv
`timescale 1ns/10ps
module sfr_window_model (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_wr,
   input  wire logic [1:0]  i_we_lane,
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_win_sel,
   output logic      [15:0] o_sfr_rdata,
   output logic      [15:0] o_win_rdata
);
   // ====
   // Registers at 0x00-0x1F
   logic [15:0] regs_r [16];
   assign o_sfr_rdata = (i_addr < 16'h0020) ? regs_r[i_addr[4:1]] : 16'h0000;
   assign o_win_rdata = i_win_sel ? 16'hC35A : 16'h3CA5;
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (int k = 0; k < 16; k++) regs_r[k] <= 16'h0000;
      end else if (i_wr && i_addr < 16'h0020) begin
         if (i_we_lane[0]) regs_r[i_addr[4:1]][7:0] <= i_wdata[7:0];
         if (i_we_lane[1]) regs_r[i_addr[4:1]][15:8] <= i_wdata[15:8];
      end
   end
endmodule

// File: test/data_space_address_decode_checker.sv
`timescale 1ns/10ps
module data_space_address_decode_checker #(
   parameter int IMPL_BYTES = 2048
) (
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_ce,
   input wire logic        i_req,
   input wire logic        i_write,
   input wire logic        i_byte,
   input wire logic        i_near_mode,
   input wire logic [12:0] i_near_field,
   input wire logic [15:0] i_effective_addr,
   input wire logic        i_post_inc,
   input wire logic        i_err_clear,
   input wire logic        i_pc_step,
   input wire logic        i_pc_down,
   input wire logic        i_pc_load,
   input wire logic [23:0] i_pc_load_addr,
   input wire logic        o_rvalid,
   input wire logic [15:0] o_rdata,
   input wire logic [15:0] o_next_pointer,
   input wire logic        o_sfr_wr,
   input wire logic [1:0]  o_sfr_we_lane,
   input wire logic        o_window_sel,
   input wire logic        o_addr_err_trap,
   input wire logic        o_addr_err_flag,
   input wire logic [23:0] o_program_counter
);
   wire [15:0] ea = i_near_mode ? {3'h0, i_near_field} : i_effective_addr;
   wire        odd_a = ea[0];
   wire        odd_w = i_req && !i_byte && odd_a;
   wire        rd_a = i_req && !i_write;
   wire [22:0] ld_hi = i_pc_load_addr[23:1];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst || !i_ce);
   a_trap_on_odd: assert property (odd_w |=> o_addr_err_trap)
      else $error("no trap on odd word access");
   a_flag_with_trap: assert property (o_addr_err_trap |-> o_addr_err_flag)
      else $error("flag not set with trap");
   a_flag_sticky: assert property (o_addr_err_flag && !i_err_clear |=> o_addr_err_flag)
      else $error("flag dropped");
   a_write_blocked: assert property (odd_w && i_write |=> !o_sfr_wr)
      else $error("misaligned write not blocked");
   a_post_step: assert property (i_req && i_post_inc |=>
      o_next_pointer == $past(ea) + ($past(i_byte) ? 16'h0001 : 16'h0002))
      else $error("post increment wrong");
   a_byte_low_lane: assert property (rd_a && i_byte |-> ##2 o_rvalid && o_rdata[15:8] == 8'h00)
      else $error("byte read high lane not zero");
   a_unimpl_zero: assert property (rd_a && !ea[15] && int'(ea) >= IMPL_BYTES |-> ##2 o_rdata == 16'h0000)
      else $error("unimplemented read not zero");
   a_lane_strobe: assert property (i_req && i_write && i_byte && ea <= 16'h07FF |=>
      o_sfr_wr && o_sfr_we_lane == ($past(odd_a) ? 2'h2 : 2'h1))
      else $error("byte lane strobe wrong");
   a_window_pick: assert property (rd_a && ea[15] |=> o_window_sel)
      else $error("window not selected");
   a_pc_load: assert property (i_pc_load |=> o_program_counter == {$past(ld_hi), 1'b0})
      else $error("program counter load wrong");
   a_pc_step: assert property (i_pc_step && !i_pc_load |=>
      o_program_counter - $past(o_program_counter) == ($past(i_pc_down) ? 24'hFFFFFE : 24'h000002))
      else $error("program counter step wrong");
   c_odd_trap: cover property (odd_w ##1 o_addr_err_trap);
   c_window: cover property (o_window_sel);
   c_clear: cover property (o_addr_err_flag ##1 !o_addr_err_flag);
endmodule
bind data_space_address_decode data_space_address_decode_checker #(.IMPL_BYTES(IMPL_BYTES)) chk (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_req(i_req), .i_write(i_write), .i_byte(i_byte),
   .i_near_mode(i_near_mode), .i_near_field(i_near_field), .i_effective_addr(i_effective_addr),
   .i_post_inc(i_post_inc), .i_err_clear(i_err_clear), .i_pc_step(i_pc_step), .i_pc_down(i_pc_down),
   .i_pc_load(i_pc_load), .i_pc_load_addr(i_pc_load_addr), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
   .o_next_pointer(o_next_pointer), .o_sfr_wr(o_sfr_wr), .o_sfr_we_lane(o_sfr_we_lane),
   .o_window_sel(o_window_sel), .o_addr_err_trap(o_addr_err_trap), .o_addr_err_flag(o_addr_err_flag),
   .o_program_counter(o_program_counter));

// File: test/data_space_address_decode_tb.sv
`timescale 1ns/10ps
module data_space_address_decode_tb;
   localparam int IMPL = 4096;
   logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_req = 1'b0, i_write = 1'b0, i_byte = 1'b0;
   logic        i_near_mode = 1'b0, i_post_inc = 1'b0, i_err_clear = 1'b0, i_ce = 1'b1;
   logic        i_pc_step = 1'b0, i_pc_down = 1'b0, i_pc_load = 1'b0;
   logic [12:0] i_near_field = 13'h0000;
   logic [15:0] i_effective_addr = 16'h0000, i_wdata = 16'h0000, i_wreg_old = 16'h0000;
   logic [1:0]  i_ext_op = 2'h0;
   logic [23:0] i_pc_load_addr = 24'h000000;
   logic [15:0] sfr_rdata, win_rdata, o_rdata, o_wreg_new, o_next_pointer, o_sfr_addr, o_sfr_wdata;
   logic [23:0] o_program_counter;
   logic [14:0] o_window_addr;
   logic [1:0]  o_sfr_we_lane;
   logic        o_rvalid, o_sfr_wr, o_window_sel, o_addr_err_trap, o_addr_err_flag;
   logic        o_in_vectors, o_in_ivt1, o_in_ivt2;
   logic [15:0] sh [2048];
   logic [23:0] pl [5] = '{24'h000003, 24'h0000FA, 24'h0000FE, 24'h0001FE, 24'h000200};
   int          n_fail = 0;
   int          checks_done = 0;
   always #4 i_clk = ~i_clk;
   data_space_address_decode #(.IMPL_BYTES(IMPL)) dut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_req(i_req), .i_write(i_write), .i_byte(i_byte),
      .i_near_mode(i_near_mode), .i_near_field(i_near_field), .i_effective_addr(i_effective_addr),
      .i_wdata(i_wdata), .i_post_inc(i_post_inc), .i_sfr_hit(1'b0), .i_sfr_rdata(sfr_rdata),
      .i_wreg_old(i_wreg_old), .i_ext_op(i_ext_op), .i_window_rdata(win_rdata), .i_pc_step(i_pc_step),
      .i_pc_down(i_pc_down), .i_pc_load(i_pc_load), .i_pc_load_addr(i_pc_load_addr),
      .i_err_clear(i_err_clear), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_wreg_new(o_wreg_new),
      .o_next_pointer(o_next_pointer), .o_sfr_wr(o_sfr_wr), .o_sfr_we_lane(o_sfr_we_lane),
      .o_sfr_addr(o_sfr_addr), .o_sfr_wdata(o_sfr_wdata), .o_window_sel(o_window_sel),
      .o_window_addr(o_window_addr), .o_addr_err_trap(o_addr_err_trap), .o_addr_err_flag(o_addr_err_flag),
      .o_program_counter(o_program_counter), .o_in_vectors(o_in_vectors), .o_in_ivt1(o_in_ivt1),
      .o_in_ivt2(o_in_ivt2));
   sfr_window_model mdl (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(o_sfr_wr), .i_we_lane(o_sfr_we_lane), .i_addr(o_sfr_addr),
      .i_wdata(o_sfr_wdata), .i_win_sel(o_window_sel), .o_sfr_rdata(sfr_rdata), .o_win_rdata(win_rdata));
   // ====
   // Checks and expectations
   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h got %h", nm, exp, got);
      end
   endtask
   function automatic logic [15:0] exp_rd(input logic [15:0] a, input logic b);
      logic [15:0] w;
      w = a[15] ? 16'hC35A : (a < IMPL) ? sh[a[11:1]] : 16'h0000;
      if (b) w = a[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
      return w;
   endfunction
   function automatic logic [15:0] exp_wr(input logic [7:0] v, input logic [15:0] old, input logic [1:0] op);
      case (op)
         dsad_pkg::EXT_ZERO: return {8'h00, v};
         dsad_pkg::EXT_SIGN: return {{8{v[7]}}, v};
         default: return {old[15:8], v};
      endcase
   endfunction
   task automatic end_sim;
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ====
   // Access tasks
   task automatic acc(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
      logic nm;
      nm = (a < 16'h2000) && ($urandom_range(1) == 1);
      @(posedge i_clk);
      i_req <= 1'b1;
      i_write <= w;
      i_byte <= b;
      i_near_mode <= nm;
      i_near_field <= a[12:0];
      i_effective_addr <= nm ? 16'($urandom) : a;
      i_wdata <= d;
      i_post_inc <= 1'($urandom_range(1));
      i_wreg_old <= 16'($urandom);
      i_ext_op <= 2'($urandom_range(2));
      @(posedge i_clk);
      i_req <= 1'b0;
   endtask
   task automatic rd(input logic b, input logic [15:0] a);
      acc(1'b0, b, a, 16'h0000);
      @(posedge i_clk);
      #1;
      chk("rvalid", 24'h000001, o_rvalid);
      chk("rdata", exp_rd(a, b), o_rdata);
      chk("win_addr", 24'(a[14:0]), 24'(o_window_addr));
      if (b) chk("wreg", exp_wr(8'(exp_rd(a, b)), i_wreg_old, i_ext_op), o_wreg_new);
   endtask
   task automatic wr(input logic b, input logic [15:0] a, input logic [15:0] d);
      acc(1'b1, b, a, d);
      if (a < 16'h0020 || (a >= 16'h0800 && a < IMPL)) begin
         if (!b) sh[a[11:1]] = d;
         else if (a[0]) sh[a[11:1]][15:8] = d[7:0];
         else sh[a[11:1]][7:0] = d[7:0];
      end
   endtask
   // ====
   // Main sequence
   initial begin
      logic [15:0] a;
      logic        b;
      logic [23:0] p;
      void'($urandom(76));
      foreach (sh[j]) sh[j] = 16'h0000;
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1;
      chk("pc_rst", 24'h000000, o_program_counter);
      chk("vec_rst", 24'h000001, o_in_vectors);
      for (int k = 0; k < IMPL; k += 2) if (k < 32 || k >= 16'h0800) wr(1'b0, 16'(k), 16'($urandom));
      repeat (400) begin
         a = 16'($urandom);
         case ($urandom_range(3))
            0: a = 16'h0800 + (a & 16'h07FF);
            1: a = a & 16'h003F;
            2: a = a & 16'h7FFF;
            default: ;
         endcase
         b = 1'($urandom_range(1));
         if (!b) a[0] = 1'b0;
         if ($urandom_range(1)) wr(b, a, 16'($urandom));
         else rd(b, a);
      end
      foreach (pl[j]) begin
         acc(1'b1, 1'b0, (j % 2) ? 16'h0005 : 16'h0903, 16'h1234);
         #1;
         chk("trap", 24'h000001, o_addr_err_trap);
         chk("flag", 24'h000001, o_addr_err_flag);
         rd(1'b0, (j % 2) ? 16'h0005 : 16'h0903);
         @(posedge i_clk);
         i_err_clear <= 1'b1;
         @(posedge i_clk);
         i_err_clear <= 1'b0;
         #1;
         chk("flag_clr", 24'h000000, o_addr_err_flag);
         @(posedge i_clk);
         i_pc_load <= 1'b1;
         i_pc_load_addr <= pl[j];
         @(posedge i_clk);
         i_pc_load <= 1'b0;
         i_pc_step <= 1'b1;
         i_pc_down <= (j == 4);
         repeat (2) @(posedge i_clk);
         i_pc_step <= 1'b0;
         repeat (2) @(posedge i_clk);
         #1;
         p = (j == 4) ? 24'h0001FC : {pl[j][23:1], 1'b0} + 24'h000004;
         chk("pc", p, o_program_counter);
         chk("vec", 24'(p < 24'h000200), o_in_vectors);
         chk("ivt1", 24'(p >= 24'h000004 && p <= 24'h0000FF), o_in_ivt1);
         chk("ivt2", 24'(p >= 24'h000100 && p <= 24'h0001FF), o_in_ivt2);
      end
      // ====
      // Clock enable low freezes state, then reset in mid-run
      @(posedge i_clk);
      i_ce <= 1'b0;
      i_pc_step <= 1'b1;
      acc(1'b1, 1'b0, 16'h0903, 16'h1234);
      #1;
      chk("ce_trap", 24'h000000, o_addr_err_trap);
      chk("ce_pc", 24'h0001FC, o_program_counter);
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      i_ce <= 1'b1;
      i_pc_step <= 1'b0;
      @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1;
      chk("pc_rst2", 24'h000000, o_program_counter);
      chk("vec_rst2", 24'h000001, o_in_vectors);
      chk("flag_rst2", 24'h000000, o_addr_err_flag);
      end_sim();
   end
   initial begin
      #400000;
      n_fail++;
      end_sim();
   end
endmodule
